// ---- input_delay_params.svh ----
// Offsets, field ranges, reset values and tap figures for the input delay block
`ifndef INPUT_DELAY_PARAMS_SVH
`define INPUT_DELAY_PARAMS_SVH

`define TAP_COUNT 32
`define TAP_W 5
`define TAP_ZERO 5'h00
`define TAP_STEP_PS 105
`define CLK_PERIOD_PS 4000
`define TAP_STEP_CYCLES (((`TAP_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))

`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004

`define CTRL_MODE_F 2:0
`define CTRL_TAP_F 12:8
`define CTRL_RX_BIT 16
`define CTRL_DYN_BIT 17

`define STAT_STATIC_F 4:0
`define STAT_DYN_F 12:8
`define STAT_CODE_F 20:16
`define STAT_DYN_BIT 24
`define STAT_BYPASS_BIT 25

`define MANUAL_TAP_RST 5'h00
`define RX_RST 1'b1
`define DYN_RST 1'b0
`define CODE_RST 5'h00

`define TAPS_ZERO_HOLD 5'h10
`define TAPS_SCLK_ALIGNED 5'h08
`define TAPS_SCLK_CENTERED 5'h00
`define TAPS_ECLK_ALIGNED 5'h04
`define TAPS_ECLK_CENTERED 5'h00

`endif

// ---- input_delay_pkg.sv ----
// Types shared by the input delay block
package input_delay_pkg;
	typedef enum logic [2:0]
	{
		mode_manual,
		mode_sclk_zero_hold,
		mode_sclk_aligned,
		mode_sclk_centered,
		mode_eclk_aligned,
		mode_eclk_centered,
		mode_bypass
	} delay_mode_t;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed
	{
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage

// ---- tap_delay_line.sv ----
// Tap delay line: one clock stage per tap, registered tap output
`timescale 1ns/1ps
`include "input_delay_params.svh"

module tap_delay_line
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic data_in,
	input wire logic [`TAP_W-1:0] taps_in,
	output logic data_out
);
	logic [`TAP_COUNT-2:0] stages;
	logic [`TAP_W-1:0] prev_tap;
	logic picked;

	assign prev_tap = taps_in - `TAP_W'(1);
	// Tap zero takes the input itself, so it has the least insertion delay
	assign picked = (taps_in == `TAP_ZERO) ? data_in : stages[prev_tap];

	genvar i;
	generate
		for (i = 0; i < `TAP_COUNT - 1; i++)
		begin : g_stage
			always_ff @(posedge clk_in)
			begin
				if (!reset_n_in)
					stages[i] <= 1'b0;
				else if (i == 0)
					stages[i] <= data_in;
				else
					stages[i] <= stages[(i == 0) ? 0 : i - 1];
			end
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			data_out <= 1'b0;
		else
			data_out <= picked;
	end
endmodule

// ---- input_data_delay_taps.sv ----
// Input data delay taps: static and dynamic data delay, clock slave delay, APB registers
`timescale 1ns/1ps
`include "input_delay_params.svh"

// What this block does
// - Optional 32-tap static delay before capture
// - Each static tap adds one step
// - Seven static modes including bypass, manual is default
// - Manual mode applies tap value 0..31
// - Preset modes fix taps by interface
// - Static delay only on receive paths
// - Bottom side offers dynamic 5-bit delay
// - Each dynamic tap adds one step
// - Slave cell shifts clock ninety degrees
// - Slave delay follows strobe DLL code
// - Code changes only while update low
module input_data_delay_taps
#(
	parameter bit BOTTOM_SIDE = 1'b1
)
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire input_delay_pkg::apb_req_t apb_in,
	output input_delay_pkg::apb_rsp_t apb_out,
	input wire logic data_pad_in,
	input wire logic [`TAP_W-1:0] tap_select_bits_in,
	input wire logic slave_clock_in,
	input wire logic [`TAP_W-1:0] dll_delay_code_in,
	input wire logic code_update_n_in,
	output logic delayed_data_out,
	output logic slave_clock_out
);
	input_delay_pkg::delay_mode_t delay_mode_select;
	logic [`TAP_W-1:0] manual_tap_value;
	logic rx_path;
	logic dyn_request;
	logic [`TAP_W-1:0] held_code;
	logic [31:0] prdata;
	logic pad_s1, pad_s2, pad_s3, pad_level;
	logic clk_s1, clk_s2, clk_s3, clk_level;
	logic line_q;

	// Preset tap count for each interface type
	function automatic logic [`TAP_W-1:0] preset_taps(input input_delay_pkg::delay_mode_t m);
		unique case (m)
			input_delay_pkg::mode_sclk_zero_hold: preset_taps = `TAPS_ZERO_HOLD;
			input_delay_pkg::mode_sclk_aligned: preset_taps = `TAPS_SCLK_ALIGNED;
			input_delay_pkg::mode_sclk_centered: preset_taps = `TAPS_SCLK_CENTERED;
			input_delay_pkg::mode_eclk_aligned: preset_taps = `TAPS_ECLK_ALIGNED;
			input_delay_pkg::mode_eclk_centered: preset_taps = `TAPS_ECLK_CENTERED;
			input_delay_pkg::mode_manual,
			input_delay_pkg::mode_bypass: preset_taps = `TAP_ZERO;
			default: preset_taps = `TAP_ZERO;
		endcase
	endfunction

	function automatic logic legal_mode(input logic [2:0] code);
		legal_mode = code <= 3'(input_delay_pkg::mode_bypass);
	endfunction

	// APB decode
	wire logic access = apb_in.psel && apb_in.penable;
	wire logic setup = apb_in.psel && !apb_in.penable;
	wire logic hit_ctrl = apb_in.paddr == `REG_CTRL;
	wire logic hit_status = apb_in.paddr == `REG_STATUS;
	wire logic hit = hit_ctrl || hit_status;
	wire logic ctrl_write = access && apb_in.pwrite && hit_ctrl;
	wire logic [2:0] wr_mode = apb_in.pwdata[`CTRL_MODE_F];

	// Path selection
	// Dynamic taps on bottom side
	wire logic use_dyn = BOTTOM_SIDE && dyn_request;
	wire logic manual_sel = delay_mode_select == input_delay_pkg::mode_manual;
	wire logic static_bypass = !rx_path || delay_mode_select == input_delay_pkg::mode_bypass;
	wire logic direct_path = static_bypass && !use_dyn;
	wire logic [`TAP_W-1:0] static_taps = !rx_path ? `TAP_ZERO :
		(manual_sel ? manual_tap_value : preset_taps(delay_mode_select));
	wire logic [`TAP_W-1:0] line_taps = use_dyn ? tap_select_bits_in : static_taps;

	wire logic [31:0] status_word = {6'h00, static_bypass, use_dyn, 3'h0, held_code,
		3'h0, tap_select_bits_in & {`TAP_W{use_dyn}}, 3'h0, static_taps};
	wire logic [31:0] ctrl_word = {14'h0000, dyn_request, rx_path, 3'h0, manual_tap_value,
		5'h00, delay_mode_select};

	assign apb_out.prdata = prdata;
	assign apb_out.pready = 1'b1;
	assign apb_out.pslverr = access && !hit;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			delay_mode_select <= input_delay_pkg::mode_manual;
			manual_tap_value <= `MANUAL_TAP_RST;
			rx_path <= `RX_RST;
			dyn_request <= `DYN_RST;
		end
		else if (ctrl_write)
		begin
			if (legal_mode(wr_mode))
				delay_mode_select <= input_delay_pkg::delay_mode_t'(wr_mode);
			manual_tap_value <= apb_in.pwdata[`CTRL_TAP_F];
			rx_path <= apb_in.pwdata[`CTRL_RX_BIT];
			dyn_request <= apb_in.pwdata[`CTRL_DYN_BIT];
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			prdata <= 32'h00000000;
		else if (setup && !apb_in.pwrite)
			prdata <= hit_ctrl ? ctrl_word : (hit_status ? status_word : 32'h00000000);
	end

	// Pad synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			{pad_s1, pad_s2, pad_s3, pad_level} <= 4'h0;
			{clk_s1, clk_s2, clk_s3, clk_level} <= 4'h0;
		end
		else
		begin
			pad_s1 <= data_pad_in;
			pad_s2 <= pad_s1;
			pad_s3 <= pad_s2;
			clk_s1 <= slave_clock_in;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			if (pad_s2 == pad_s3)
				pad_level <= pad_s3;
			if (clk_s2 == clk_s3)
				clk_level <= clk_s3;
		end
	end

	// Code is held unless the update control is low
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			held_code <= `CODE_RST;
		else if (!code_update_n_in)
			held_code <= dll_delay_code_in;
	end

	// Shared data delay line, static or dynamic taps
	tap_delay_line u_data_line
	(
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.data_in(pad_level),
		.taps_in(line_taps),
		.data_out(line_q)
	);

	// Slave clock delayed by the quarter-period code
	tap_delay_line u_clock_line
	(
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.data_in(clk_level),
		.taps_in(held_code),
		.data_out(slave_clock_out)
	);

	// Transmit setting and bypass mode skip the line when dynamic taps are off
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			delayed_data_out <= 1'b0;
		else
			delayed_data_out <= direct_path ? pad_level : line_q;
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	chk_manual_tap_applied: assert property (
		rx_path && manual_sel |-> static_taps == manual_tap_value)
		else $error("manual tap value not applied");

	chk_preset_tap_fixed: assert property (
		rx_path && !manual_sel && delay_mode_select != input_delay_pkg::mode_bypass
		|-> static_taps == preset_taps(delay_mode_select))
		else $error("preset taps do not match mode");

	chk_tx_no_delay: assert property (
		(!rx_path && !use_dyn) [*3] |-> delayed_data_out == $past(pad_level, 1))
		else $error("transmit path was delayed");

	chk_mode_write_takes: assert property (
		ctrl_write && legal_mode(wr_mode) |=> delay_mode_select == $past(wr_mode))
		else $error("mode write lost");

	chk_dynamic_taps_used: assert property (
		use_dyn |-> line_taps == tap_select_bits_in)
		else $error("dynamic taps not routed");

	chk_zero_tap_least: assert property (
		(line_taps == `TAP_ZERO && !direct_path) [*3] |-> delayed_data_out == $past(pad_level, 2))
		else $error("tap zero insertion wrong");

	chk_one_tap_step: assert property (
		(line_taps == `TAP_W'(`TAP_STEP_CYCLES) && !direct_path) [*4]
		|-> delayed_data_out == $past(pad_level, 3))
		else $error("one tap does not add one step");

	chk_dyn_tap_step: assert property (
		(use_dyn && tap_select_bits_in == `TAP_W'(2)) [*5] |-> delayed_data_out == $past(pad_level, 4))
		else $error("dynamic tap step wrong");

	chk_code_hold: assert property (
		code_update_n_in |=> $stable(held_code))
		else $error("code changed while held");

	chk_code_follow: assert property (
		!code_update_n_in |=> held_code == $past(dll_delay_code_in))
		else $error("code not taken on update");

	chk_slave_shift: assert property (
		(held_code == `TAP_W'(1)) [*3] |-> slave_clock_out == $past(clk_level, 2))
		else $error("slave clock shift wrong");

	cov_manual_mode: cover property (rx_path && manual_sel && manual_tap_value == `TAP_W'(31));
	cov_dynamic_change: cover property (use_dyn && !$stable(tap_select_bits_in));
	cov_code_update: cover property (!code_update_n_in ##1 code_update_n_in);
	cov_bad_addr: cover property (apb_out.pslverr);
endmodule

// ---- pad_fabric_model.sv ----
// Pad buffer and fabric model driving the delay block's data, clock and tap inputs
`timescale 1ns/1ps
`include "input_delay_params.svh"

module pad_fabric_model
(
	input wire logic clk_in,
	input wire logic level_in,
	input wire logic [`TAP_W-1:0] tap_req_in,
	output logic pad_out,
	output logic clock_pad_out,
	output logic [`TAP_W-1:0] tap_select_bits_out
);
	// Pad levels follow the requested level one cycle later
	always_ff @(posedge clk_in)
	begin
		pad_out <= level_in;
		clock_pad_out <= level_in;
	end

	always_ff @(posedge clk_in)
	begin
		tap_select_bits_out <= tap_req_in;
	end
endmodule

// ---- input_data_delay_taps_tb_top.sv ----
// Testbench for the input data delay taps block
`timescale 1ns/1ps
`include "input_delay_params.svh"

module input_data_delay_taps_tb_top;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	input_delay_pkg::apb_req_t req = '0;
	input_delay_pkg::apb_rsp_t rsp;
	logic lvl = 1'b0;
	logic [`TAP_W-1:0] tap_req = 5'h00;
	logic [`TAP_W-1:0] code = 5'h00;
	logic code_upd_n = 1'b1;
	logic pad, clk_pad, dout, sclk_out;
	logic [`TAP_W-1:0] tsel;
	logic [31:0] rd;
	logic er;
	int errors = 0;
	int cmp_count = 0;
	int base, n;
	logic [4:0] preset [6] = '{5'h07, `TAPS_ZERO_HOLD, `TAPS_SCLK_ALIGNED,
		`TAPS_SCLK_CENTERED, `TAPS_ECLK_ALIGNED, `TAPS_ECLK_CENTERED};

	pad_fabric_model i_pad_fabric_model (.clk_in(clk_in), .level_in(lvl), .tap_req_in(tap_req),
		.pad_out(pad), .clock_pad_out(clk_pad), .tap_select_bits_out(tsel));

	input_data_delay_taps i_input_data_delay_taps (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.apb_in(req), .apb_out(rsp), .data_pad_in(pad), .tap_select_bits_in(tsel),
		.slave_clock_in(clk_pad), .dll_delay_code_in(code), .code_update_n_in(code_upd_n),
		.delayed_data_out(dout), .slave_clock_out(sclk_out));

	initial
	begin
		forever #2 clk_in = ~clk_in;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_in);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk_in);
		req.penable <= 1'b1;
		// Request stands until pready is seen high at a rising edge
		do
		begin
			@(posedge clk_in);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 50);
		if (k >= 50)
			errors++;
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	function automatic logic [31:0] ctrl(logic [2:0] m, logic [4:0] t, logic rx, logic dy);
		return {14'h0000, dy, rx, 3'h0, t, 5'h00, m};
	endfunction

	// Step the pad level and count cycles until the chosen output follows
	task measure(input bit slave, output int cnt);
		lvl <= 1'b0;
		repeat (45) @(posedge clk_in);
		lvl <= 1'b1;
		cnt = 0;
		do
		begin
			@(negedge clk_in);
			cnt++;
		end
		while ((slave ? sclk_out : dout) !== 1'b1 && cnt < 100);
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_in);
		errors++;
		print_verdict();
	end

	initial
	begin
		repeat (12) @(posedge clk_in);
		reset_n_in <= 1'b1;
		xfer(1'b0, `REG_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0001_0000);
		xfer(1'b0, `REG_STATUS, 32'h0);
		check("status reset", rd, 32'h0000_0000);
		xfer(1'b0, 12'h0FC, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		$display("test registers done");
		// Each preset matched to its interface
		for (int m = 0; m < 6; m++)
		begin
			xfer(1'b1, `REG_CTRL, ctrl(m[2:0], 5'h07, 1'b1, 1'b0));
			xfer(1'b0, `REG_STATUS, 32'h0);
			check("preset taps", {27'h0, rd[4:0]}, {27'h0, preset[m]});
		end
		xfer(1'b1, `REG_CTRL, ctrl(3'h6, 5'h00, 1'b1, 1'b0));
		xfer(1'b0, `REG_STATUS, 32'h0);
		check("bypass flag", {31'h0, rd[25]}, 32'h1);
		$display("test modes done");
		xfer(1'b1, `REG_CTRL, ctrl(3'h0, 5'h00, 1'b1, 1'b0));
		measure(1'b0, base);
		foreach (preset[i])
		begin
			xfer(1'b1, `REG_CTRL, ctrl(3'h0, 5'h1F - 5'(i * 6), 1'b1, 1'b0));
			measure(1'b0, n);
			check("static delay", 32'(n - base), 32'(31 - i * 6));
		end
		xfer(1'b1, `REG_CTRL, ctrl(3'h0, 5'h05, 1'b0, 1'b0));
		measure(1'b0, n);
		check("transmit direct", 32'(base - n), 32'h1);
		$display("test static delay done");
		tap_req <= 5'h09;
		xfer(1'b1, `REG_CTRL, ctrl(3'h0, 5'h03, 1'b1, 1'b1));
		measure(1'b0, n);
		check("dynamic delay", 32'(n - base), 32'h9);
		tap_req <= 5'h1F;
		measure(1'b0, n);
		check("dynamic max", 32'(n - base), 32'h1F);
		$display("test dynamic delay done");
		code <= 5'h06;
		code_upd_n <= 1'b0;
		@(posedge clk_in);
		code_upd_n <= 1'b1;
		code <= 5'h14;
		measure(1'b1, n);
		check("slave delay", 32'(n - base), 32'h5);
		xfer(1'b0, `REG_STATUS, 32'h0);
		check("held code", {27'h0, rd[20:16]}, 32'h6);
		$display("test slave delay done");
		print_verdict();
	end
endmodule
